/* File: rtl/trap_ctl_regs.v */
// Trap status, nesting control, vector select and external edge polarity
// Assumes trap sources give one-cycle pulses on core_clk; ext pins are async
`timescale 1ns/1ns
`include "trap_ctl_defines.vh"

module trap_ctl_regs (
   input  wire        core_clk,        // System clock 250 MHz
   input  wire        rst_b,           // Async reset, active low
   input  wire [4:0]  s_axi_awaddr,    // Write address
   input  wire        s_axi_awvalid,   // Write address valid
   output wire        s_axi_awready,   // Write address ready
   input  wire [31:0] s_axi_wdata,     // Write data
   input  wire [3:0]  s_axi_wstrb,     // Write strobes
   input  wire        s_axi_wvalid,    // Write data valid
   output wire        s_axi_wready,    // Write data ready
   output reg  [1:0]  s_axi_bresp,     // Write response
   output reg         s_axi_bvalid,    // Write response valid
   input  wire        s_axi_bready,    // Write response ready
   input  wire [4:0]  s_axi_araddr,    // Read address
   input  wire        s_axi_arvalid,   // Read address valid
   output wire        s_axi_arready,   // Read address ready
   output reg  [31:0] s_axi_rdata,     // Read data
   output reg  [1:0]  s_axi_rresp,     // Read response
   output reg         s_axi_rvalid,    // Read response valid
   input  wire        s_axi_rready,    // Read response ready
   input  wire        acc_a_ovf,       // Accumulator A overflow pulse
   input  wire        acc_b_ovf,       // Accumulator B overflow pulse
   input  wire        acc_a_cat_ovf,   // Accumulator A catastrophic pulse
   input  wire        acc_b_cat_ovf,   // Accumulator B catastrophic pulse
   input  wire        bad_shift_evt,   // Invalid shift pulse
   input  wire        div_zero_evt,    // Divide by zero pulse
   input  wire        dma_fault_evt,   // DMA controller error pulse
   input  wire        addr_fault_evt,  // Address error pulse
   input  wire        stack_fault_evt, // Stack error pulse
   input  wire        osc_fault_evt,   // Oscillator failure pulse
   input  wire        irq_hold_active, // Interrupt-disable instruction active
   input  wire [2:0]  ipl_wr_data,     // Core write to priority level
   input  wire        ipl_wr_en,       // Core priority level write strobe
   input  wire [4:0]  ext_irq_pin,     // External interrupt pins, async
   output reg  [2:0]  cpu_priority_level, // Current priority level
   output wire        nesting_disable, // Nesting blocked
   output wire        alt_vector_select, // Use alternate vector table
   output wire        math_trap,       // Math trap request level
   output wire [4:0]  ext_irq_req,     // Sticky external requests
   output wire        irq              // Level interrupt output
);

   ////////////////////////////////////////////////////////////////////////
   // Reset release
   reg        rst_s1_r;
   reg        rst_n_r;
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   reg  [15:0] ctl1_r;
   reg  [15:0] ctl2_r;
   reg  [3:0]  stat_r;
   reg  [3:0]  mask_r;
   reg  [4:0]  ext_req_r;
   reg  [15:0] ctl1_nxt;
   reg  [3:0]  stat_nxt;
   reg  [4:0]  ext_req_nxt;

   // Byte-lane merge of 16-bit write
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] wd;
      input [3:0]  st;
      begin
         merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Write channel: both address and data taken together
   wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   wire [15:0] wmerge1 = merge16(ctl1_r, s_axi_wdata, s_axi_wstrb);
   wire [15:0] wmerge2 = merge16(ctl2_r, s_axi_wdata, s_axi_wstrb);
   wire wr1 = wr_go & (s_axi_awaddr == `ADDR_CTL1);
   wire wr2 = wr_go & (s_axi_awaddr == `ADDR_CTL2);
   wire wr_st = wr_go & (s_axi_awaddr == `ADDR_IRQ_STAT) & s_axi_wstrb[0];
   wire wr_mk = wr_go & (s_axi_awaddr == `ADDR_IRQ_MASK) & s_axi_wstrb[0];
   wire wr_ex = wr_go & (s_axi_awaddr == `ADDR_EXT_REQ) & s_axi_wstrb[0];
   wire wr_ok = (s_axi_awaddr == `ADDR_CTL1) | (s_axi_awaddr == `ADDR_CTL2) |
                (s_axi_awaddr == `ADDR_IRQ_STAT) | (s_axi_awaddr == `ADDR_IRQ_MASK) |
                (s_axi_awaddr == `ADDR_EXT_REQ);

   ////////////////////////////////////////////////////////////////////////
   // Trap flag sets; set wins over software clear
   reg [15:0] set1;
   always @* begin
      set1 = 16'h0000;
      set1[`B_OVA_FLAG]   = acc_a_ovf & ctl1_r[`B_OVA_TE];       // R3 R5
      set1[`B_OVB_FLAG]   = acc_b_ovf & ctl1_r[`B_OVB_TE];       // R3 R5
      set1[`B_COVA_FLAG]  = acc_a_cat_ovf & ctl1_r[`B_COV_TE];   // R4 R6
      set1[`B_COVB_FLAG]  = acc_b_cat_ovf & ctl1_r[`B_COV_TE];   // R4 R6
      set1[`B_SHIFT_FLAG] = bad_shift_evt;                       // R7
      set1[`B_DIV0_FLAG]  = div_zero_evt;                        // R8
      set1[`B_DMA_FLAG]   = dma_fault_evt;                       // R9
      set1[`B_MATH_FLAG]  = set1[`B_OVA_FLAG] | set1[`B_OVB_FLAG] |
                            set1[`B_COVA_FLAG] | set1[`B_COVB_FLAG] |
                            bad_shift_evt | div_zero_evt;        // R10
      set1[`B_ADDR_FLAG]  = addr_fault_evt;                      // R11
      set1[`B_STK_FLAG]   = stack_fault_evt;                     // R12
      set1[`B_OSC_FLAG]   = osc_fault_evt;                       // R13
   end

   // Next value of first control register
   always @* begin
      ctl1_nxt = ctl1_r;
      if (wr1) begin
         ctl1_nxt = (ctl1_r & ~`CTL1_WR_MASK) | (wmerge1 & `CTL1_WR_MASK);
         ctl1_nxt = ctl1_nxt & (~`CTL1_FLAG_MASK | wmerge1);     // R17
      end
      ctl1_nxt = (ctl1_nxt | set1) & ~16'h0001;                  // R13 R17
   end

   ////////////////////////////////////////////////////////////////////////
   // External interrupt synchronisers and edge detect
   reg  [4:0] ext_s1_r;
   reg  [4:0] ext_s2_r;
   reg  [4:0] ext_d_r;
   wire [4:0] ext_edge;
   genvar g;
   generate
      for (g = 0; g < `N_EXT; g = g + 1) begin : g_ext
         // Negative edge when polarity set, else positive
         assign ext_edge[g] = ctl2_r[g] ? (ext_d_r[g] & ~ext_s2_r[g])
                                        : (~ext_d_r[g] & ext_s2_r[g]); // R16 R18
      end
   endgenerate

   always @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ext_s1_r <= 5'h00;
         ext_s2_r <= 5'h00;
         ext_d_r  <= 5'h00;
      end else begin
         ext_s1_r <= ext_irq_pin;                                // R18
         ext_s2_r <= ext_s1_r;
         ext_d_r  <= ext_s2_r;
      end
   end

   // Sticky requests, write one to clear, edge wins
   always @* begin
      ext_req_nxt = ext_req_r;
      if (wr_ex)
         ext_req_nxt = ext_req_r & ~s_axi_wdata[4:0];
      ext_req_nxt = ext_req_nxt | ext_edge;                      // R18
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: W1C, events win
   wire [3:0] evt = {|ext_edge,
                     set1[`B_SHIFT_FLAG] | set1[`B_DIV0_FLAG] | set1[`B_DMA_FLAG] |
                     set1[`B_ADDR_FLAG] | set1[`B_STK_FLAG] | set1[`B_OSC_FLAG],
                     set1[`B_COVA_FLAG] | set1[`B_COVB_FLAG],
                     set1[`B_OVA_FLAG] | set1[`B_OVB_FLAG]};
   always @* begin
      stat_nxt = stat_r;
      if (wr_st)
         stat_nxt = stat_r & ~s_axi_wdata[3:0];
      stat_nxt = stat_nxt | evt;
   end
   assign irq = |(stat_r & mask_r);

   ////////////////////////////////////////////////////////////////////////
   // State registers
   always @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctl1_r    <= `CTL1_RST;
         ctl2_r    <= `CTL2_RST;
         stat_r    <= 4'h0;
         mask_r    <= 4'h0;
         ext_req_r <= 5'h00;
         cpu_priority_level <= 3'h0;
      end else begin
         ctl1_r    <= ctl1_nxt;
         stat_r    <= stat_nxt;
         ext_req_r <= ext_req_nxt;
         if (wr2)
            ctl2_r <= wmerge2 & `CTL2_WR_MASK;                    // R14 R16
         if (wr_mk)
            mask_r <= s_axi_wdata[3:0];
         if (ipl_wr_en & ~ctl1_r[`B_NEST_DIS])
            cpu_priority_level <= ipl_wr_data;                   // R2
      end
   end

   assign nesting_disable   = ctl1_r[`B_NEST_DIS];               // R1
   assign alt_vector_select = ctl2_r[`B_ALT_VEC];                // R14
   assign math_trap         = ctl1_r[`B_MATH_FLAG];
   assign ext_irq_req       = ext_req_r;

   ////////////////////////////////////////////////////////////////////////
   // Write response
   always @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel
   assign s_axi_arready = ~s_axi_rvalid;
   always @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= `ZERO32;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid & ~s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `RESP_OKAY;
         case (s_axi_araddr)
            `ADDR_CTL1:     s_axi_rdata <= {16'h0000, ctl1_r};
            `ADDR_CTL2:     s_axi_rdata <= {16'h0000, ctl2_r[15], irq_hold_active,
                                            ctl2_r[13:0]};      // R15
            `ADDR_IRQ_STAT: s_axi_rdata <= {28'h0000000, stat_r};
            `ADDR_IRQ_MASK: s_axi_rdata <= {28'h0000000, mask_r};
            `ADDR_EXT_REQ:  s_axi_rdata <= {27'h0000000, ext_req_r};
            default: begin
               s_axi_rdata <= `ZERO32;
               s_axi_rresp <= `RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

/* File: inc/trap_ctl_defines.vh */
// Constants for the trap and interrupt control register block
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers
// Overview of operation
// R1: Nesting disable bit blocks nested interrupts
// R2: Nesting disabled makes priority level read-only
// R3: Bits 14/13 flag accumulator A/B overflow
// R4: Bits 12/11 flag catastrophic overflow A/B
// R5: Bits 10/9 enable overflow traps A/B
// R6: Bit 8 enables catastrophic overflow trap
// R7: Bit 7 flags invalid accumulator shift
// R8: Bit 6 flags divide by zero
// R9: Bit 5 flags DMA controller error trap
// R10: Bit 4 flags any math error trap
// R11: Bit 3 flags address error trap
// R12: Bit 2 flags stack error trap
// R13: Bit 1 flags oscillator failure; bit 0 reads zero
// R14: Alternate vector table select at bit 15
// R15: Bit 14 shows interrupt-disable instruction active
// R16: Bits 4..0 pick negative or positive edge
// R17: Trap flags sticky until software writes zero
// R18: External inputs synchronised, one request per edge
`ifndef TRAP_CTL_DEFINES_VH
`define TRAP_CTL_DEFINES_VH

// Register byte addresses
`define ADDR_CTL1      5'h00
`define ADDR_CTL2      5'h04
`define ADDR_IRQ_STAT  5'h08
`define ADDR_IRQ_MASK  5'h0c
`define ADDR_EXT_REQ   5'h10

// First control register fields
`define B_NEST_DIS     15
`define B_OVA_FLAG     14
`define B_OVB_FLAG     13
`define B_COVA_FLAG    12
`define B_COVB_FLAG    11
`define B_OVA_TE       10
`define B_OVB_TE       9
`define B_COV_TE       8
`define B_SHIFT_FLAG   7
`define B_DIV0_FLAG    6
`define B_DMA_FLAG     5
`define B_MATH_FLAG    4
`define B_ADDR_FLAG    3
`define B_STK_FLAG     2
`define B_OSC_FLAG     1
`define CTL1_FLAG_MASK 16'h78fe
`define CTL1_WR_MASK   16'h8700
`define CTL1_RST       16'h0000

// Second control register fields
`define B_ALT_VEC      15
`define B_HOLD_ACT     14
`define CTL2_WR_MASK   16'h801f
`define CTL2_RST       16'h0000

// Status register: 0 overflow trap, 1 catastrophic trap, 2 other trap, 3 ext edge
`define N_EVT          4
`define N_EXT          5
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`define ZERO32         32'h00000000

`endif

/* File: tb/trap_ctl_regs_asserts.sv */
// Checker for the trap control register block
// Assumes binding onto trap_ctl_regs, one clock domain
`timescale 1ns/1ns
module trap_ctl_regs_chk (
   input wire logic        core_clk, rst_b, s_axi_awvalid, s_axi_wvalid, // Clock, bus
   input wire logic        s_axi_awready, s_axi_bvalid, s_axi_bready,    // Write side
   input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,   // Read side
   input wire logic        s_axi_rready, div_zero_evt, math_trap,        // Read, traps
   input wire logic        nesting_disable, ipl_wr_en,                   // Priority control
   input wire logic [4:0]  s_axi_awaddr,                                 // Write address
   input wire logic [31:0] s_axi_wdata, s_axi_rdata,                     // Bus data
   input wire logic [2:0]  ipl_wr_data, cpu_priority_level,              // Priority level
   input wire logic [4:0]  ext_irq_pin, ext_irq_req                      // External lines
);
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_b);
// Software write that clears the math flag
wire clr_math = s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_awaddr == 5'h00 && !s_axi_wdata[4];
sequence wr_taken;
   s_axi_awvalid && s_axi_wvalid && s_axi_awready;
endsequence
sequence rd_taken;
   s_axi_arvalid && s_axi_arready;
endsequence
////////////////////////////////////////
chk_write_answer: assert property (wr_taken |=> s_axi_bvalid) else $error("write unanswered");
chk_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("read unanswered");
chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
   else $error("bvalid dropped");
chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
   else $error("read data not held");
chk_div_math: assert property (div_zero_evt |=> math_trap) else $error("math flag missed");
chk_math_sticky: assert property (math_trap && !clr_math |=> math_trap) else $error("flag lost");
chk_ipl_locked: assert property (nesting_disable |=> $stable(cpu_priority_level))
   else $error("priority changed while locked");
chk_ipl_taken: assert property (ipl_wr_en && !nesting_disable |=> cpu_priority_level == $past(ipl_wr_data))
   else $error("priority write lost");
chk_ext_cause: assert property ($rose(ext_irq_req[0]) |-> $past(ext_irq_pin[0], 2) != $past(ext_irq_pin[0], 5))
   else $error("request without pin edge");
endmodule
bind trap_ctl_regs trap_ctl_regs_chk i_trap_ctl_regs_chk (.core_clk, .rst_b, .s_axi_awvalid,
   .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .div_zero_evt, .math_trap, .nesting_disable, .ipl_wr_en,
   .s_axi_awaddr, .s_axi_wdata, .s_axi_rdata, .ipl_wr_data, .cpu_priority_level, .ext_irq_pin,
   .ext_irq_req);

/* File: tb/trap_side_model.sv */
// Model of the trap sources and external pins around the block
// Assumes commands from the bench arrive just after core_clk edges
`timescale 1ns/1ns
module trap_side_model (
   input  wire       core_clk,         // System clock
   input  wire       fire,             // Request one trap pulse
   input  wire [3:0] fire_idx,         // Which trap source fires
   input  wire [4:0] pin_lvl,          // Wanted pin levels
   output reg  [9:0] evt = 10'h000,    // One-cycle trap pulses
   output reg  [4:0] pins = 5'h00      // External pins
);
// Trap pulse lasts exactly one cycle
always @(posedge core_clk) begin
   evt <= fire ? 10'h001 << fire_idx : 10'h000;
end
// Pins move mid-cycle, away from the sampling edge
always @(negedge core_clk) begin
   pins <= pin_lvl;
end
endmodule

/* File: tb/test_trap_ctl_regs.sv */
// Bench for the trap control register block over AXI4-Lite
// Assumes the design, checker and far-side model are compiled first
`timescale 1ns/1ns
`include "trap_ctl_defines.vh"
module test_trap_ctl_regs;
logic        core_clk = 0, rst_b = 0, fire = 0, irq_hold_active = 0, ipl_wr_en = 0;
logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
logic        s_axi_rready = 0;
logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
logic [3:0]  fire_idx = 0, s_axi_wstrb = 4'hf;
logic [31:0] s_axi_wdata = 0;
logic [2:0]  ipl_wr_data = 0;
logic [4:0]  pin_lvl = 0;
wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
wire         nesting_disable, alt_vector_select, math_trap;
wire [1:0]   s_axi_bresp, s_axi_rresp;
wire [31:0]  s_axi_rdata;
wire [2:0]   cpu_priority_level;
wire [4:0]   pins, ext_irq_req;
wire [9:0]   evt;
integer      fail_count = 0, checked = 0, k;
logic [15:0] exp_tab [0:9];
////////////////////////////////////////
always #2 core_clk = ~core_clk;
trap_side_model i_trap_side_model (.core_clk, .fire, .fire_idx, .pin_lvl, .evt, .pins);
trap_ctl_regs i_trap_ctl_regs (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .acc_a_ovf(evt[0]), .acc_b_ovf(evt[1]), .acc_a_cat_ovf(evt[2]),
   .acc_b_cat_ovf(evt[3]), .bad_shift_evt(evt[4]), .div_zero_evt(evt[5]), .dma_fault_evt(evt[6]),
   .addr_fault_evt(evt[7]), .stack_fault_evt(evt[8]), .osc_fault_evt(evt[9]), .irq_hold_active,
   .ipl_wr_data, .ipl_wr_en, .ext_irq_pin(pins), .cpu_priority_level, .nesting_disable,
   .alt_vector_select, .math_trap, .ext_irq_req, .irq);
// Verdict and end of run
task final_report;
   $display("checks %0d mismatches %0d", checked, fail_count);
   if (fail_count == 0 && checked > 0) $display("All checks passed");
   else $display("Checks failed");
   $finish;
endtask
task ck(input [31:0] got, input [31:0] exp);
   checked = checked + 1;
   if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
   end
endtask
// One bounded wait step
task tmo(input integer n);
   if (n > 64) begin
      fail_count = fail_count + 1;
      $display("BAD %0t no handshake", $time);
      final_report;
   end
   @(posedge core_clk);
endtask
task wr(input [4:0] a, input [31:0] d);
   integer n;
   s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
   @(posedge core_clk);
   for (n = 0; !s_axi_awready; n++) tmo(n);
   s_axi_awvalid <= 0; s_axi_wvalid <= 0;
   for (n = 0; !s_axi_bvalid; n++) tmo(n);
   s_axi_bready <= 0;
endtask
task rd(input [4:0] a, input [31:0] exp, input [1:0] er = `RESP_OKAY);
   integer n;
   s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
   @(posedge core_clk);
   for (n = 0; !s_axi_arready; n++) tmo(n);
   s_axi_arvalid <= 0;
   for (n = 0; !s_axi_rvalid; n++) tmo(n);
   s_axi_rready <= 0;
   ck(s_axi_rdata, exp);
   ck(s_axi_rresp, er);
endtask
task pulse(input [3:0] i);
   fire_idx <= i; fire <= 1;
   @(posedge core_clk);
   fire <= 0;
   repeat (2) @(posedge core_clk);
endtask
task ipl_put(input [2:0] v);
   ipl_wr_data <= v; ipl_wr_en <= 1;
   @(posedge core_clk);
   ipl_wr_en <= 0;
   repeat (2) @(posedge core_clk);
endtask
////////////////////////////////////////
initial begin
   exp_tab = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090,
               16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};
   repeat (12) @(posedge core_clk);
   rst_b <= 1;
   repeat (3) @(posedge core_clk);
   rd(`ADDR_CTL1, 32'h0);
   irq_hold_active <= 1;
   rd(`ADDR_CTL2, 32'h4000);
   wr(`ADDR_CTL1, 32'hffff);
   rd(`ADDR_CTL1, 32'h8700);
   ck(nesting_disable, 1'b1);
   ipl_put(3'h5);
   ck(cpu_priority_level, 3'h0);
   // Every trap source, then clear by writing zeros
   for (k = 0; k < 10; k++) begin
      pulse(k[3:0]);
      rd(`ADDR_CTL1, {16'h0, 16'h8700 | exp_tab[k]});
      wr(`ADDR_CTL1, 32'h8700);
      rd(`ADDR_CTL1, 32'h8700);
   end
   wr(`ADDR_CTL1, 32'h0);
   pulse(4'h0);
   pulse(4'h3);
   rd(`ADDR_CTL1, 32'h0);
   ipl_put(3'h5);
   ck(cpu_priority_level, 3'h5);
   // Interrupt raised, masked and cleared
   wr(`ADDR_IRQ_STAT, 32'hf);
   wr(`ADDR_IRQ_MASK, 32'h4);
   pulse(4'h5);
   rd(`ADDR_IRQ_STAT, 32'h4);
   ck(irq, 1'b1);
   wr(`ADDR_IRQ_MASK, 32'h0);
   repeat (2) @(posedge core_clk);
   ck(irq, 1'b0);
   wr(`ADDR_IRQ_MASK, 32'h4);
   wr(`ADDR_IRQ_STAT, 32'h4);
   repeat (2) @(posedge core_clk);
   ck(irq, 1'b0);
   // Mixed edge polarity on the external pins
   wr(`ADDR_CTL2, 32'h8015);
   rd(`ADDR_CTL2, 32'hc015);
   ck(alt_vector_select, 1'b1);
   pin_lvl <= 5'h1f;
   repeat (8) @(posedge core_clk);
   ck(ext_irq_req, 5'h0a);
   pin_lvl <= 5'h00;
   repeat (8) @(posedge core_clk);
   ck(ext_irq_req, 5'h1f);
   irq_hold_active <= 0;
   rd(`ADDR_CTL2, 32'h8015);
   rd(5'h02, 32'h0, `RESP_SLVERR);
   final_report;
end
endmodule
